// ---- hdl/icdma_pkg.sv ----
// Constants and types shared by the interrupt controller and its micro DMA engine.
// Assumes an 8-bit CPU bus with 16-bit addresses and a single 100 MHz clock.
package icdma_pkg;
  // Clock and service timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SVC_TIME_NS = 9200; // Fixed service time with count left nonzero
  localparam int SVC_CYCLES = SVC_TIME_NS / CLK_PERIOD_NS;
  localparam int SVC_CNT_W = 10;
  // Channel map
  localparam int NUM_CH = 12;
  localparam logic [7:0] VEC_DIV8_FIRST = 8'h05; // Vector/8 of channel 0
  localparam int SERIAL_CH = 3; // Serial channel, never micro DMA
  localparam int SHARED_CH = 10; // Sync flag or external input two
  localparam int EXT0_CH = 0;
  localparam int EXT1_CH = 9;
  // Register offsets
  localparam logic [15:0] ADDR_EN_LOW = 16'hFFE9;
  localparam logic [15:0] ADDR_EN_DMA_SEL = 16'hFFEA;
  localparam logic [15:0] ADDR_DMA_EN = 16'hFFEB;
  localparam logic [15:0] ADDR_PEND_LOW = 16'hFFEC;
  localparam logic [15:0] ADDR_PEND_CLR = 16'hFFED;
  localparam int SEL_BIT = 3; // Shared channel select in ADDR_EN_DMA_SEL
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Parameter block
  localparam logic [15:0] PARAM_BASE = 16'hFF00;
  localparam int PARAM_BYTES = 6;
  localparam logic [2:0] OFS_COUNT = 3'h0;
  localparam logic [2:0] OFS_DST = 3'h1;
  localparam logic [2:0] OFS_SRC = 3'h3;
  localparam logic [2:0] OFS_MODE = 3'h5;
  localparam logic [2:0] WB_LAST = 3'h4; // Write-back covers count, dst, src
  localparam int WIDTH_BIT = 2; // Mode bit for two-byte transfers
  typedef enum logic [1:0] {
    UPD_FIXED = 2'b00,
    UPD_DST_INC = 2'b01,
    UPD_SRC_INC = 2'b10,
    UPD_SRC_DEC = 2'b11
  } icdma_upd_t;
  typedef struct packed {
    logic [7:0] count;
    logic [15:0] dst;
    logic [15:0] src;
    logic [7:0] mode;
  } icdma_param_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b011,
    ST_SAVE = 3'b100,
    ST_PAD = 3'b101
  } icdma_state_t;
endpackage

// ---- hdl/icdma_top.sv ----
// Twelve-channel interrupt controller with micro DMA engine, plus its byte FIFO.
// Assumes a CPU bus that reads and writes the control bytes, a memory port with a
// one-cycle acknowledge, and same-clock internal sources; pin inputs are asynchronous.
`timescale 1ns/10ps

module icdma_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic full, empty, push, pop;

  // Extra pointer bit tells full from empty
  always_comb begin
    full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    empty = (wr_ptr_reg == rd_ptr_reg);
    push = in_valid_in && !full;
    pop = out_ready_in && !empty;
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    in_ready_out = !full;
    out_valid_out = !empty;
    out_data_out = mem_reg[rd_ptr_reg[AW-1:0]];
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // Storage carries no reset; only pointers define contents
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
    end
  end
endmodule

module icdma_top
  import icdma_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic MCLK_IN,
  input wire logic RESET_N_IN,
  input wire logic [2:0] EXT_IRQ_PIN_IN, // Zero, one, two, asynchronous
  input wire logic EXT_ZERO_TRIGGER_MODE_IN, // 0 level, 1 rising edge
  input wire logic SYNC_FLAG_IRQ_IN, // Same-clock pulse
  input wire logic [NUM_CH-1:0] INT_SRC_IN, // Same-clock internal pulses
  input wire logic [15:0] BUS_ADDR_IN,
  input wire logic [7:0] BUS_WDATA_IN,
  input wire logic BUS_WR_IN,
  input wire logic BUS_RD_IN,
  output logic [7:0] BUS_RDATA_OUT,
  output logic IRQ_OUT,
  output logic [7:0] IRQ_VECTOR_OUT,
  output logic IRQ_DMA_OUT,
  input wire logic IRQ_ACK_IN,
  output logic DMA_BUSY_OUT,
  output logic MEM_REQ_OUT,
  output logic MEM_WE_OUT,
  output logic [15:0] MEM_ADDR_OUT,
  output logic [7:0] MEM_WDATA_OUT,
  input wire logic [7:0] MEM_RDATA_IN,
  input wire logic MEM_ACK_IN
);
  // Pin synchronisers and edge history
  logic [2:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
  always_ff @(posedge MCLK_IN) begin
    if (!RESET_N_IN) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
    end else begin
      pin_s1_reg <= EXT_IRQ_PIN_IN;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  logic [7:0] en_low_reg, en_low_next, en_sel_reg, en_sel_next, dma_en_reg, dma_en_next;
  logic [NUM_CH-1:0] pend_reg, pend_next, set_vec, clr_vec, en_vec, dma_vec;
  logic [2:0] pin_rise;
  logic wr_hit_clr;

  // Flag layout: enables ch0-7 low, ch8-11 in upper nibble; DMA ch0-7, ch8-10 low bits
  always_comb begin
    en_vec = {en_sel_reg[7:4], en_low_reg};
    dma_vec = {1'b0, en_sel_reg[2:0], dma_en_reg};
    dma_vec[SERIAL_CH] = 1'b0;
  end

  // Latch set sources
  always_comb begin
    pin_rise = pin_s2_reg & ~pin_s3_reg;
    set_vec = INT_SRC_IN;
    set_vec[EXT1_CH] = pin_rise[1];
    set_vec[SHARED_CH] = en_sel_reg[SEL_BIT] ? pin_rise[2] : SYNC_FLAG_IRQ_IN;
    set_vec[EXT0_CH] = EXT_ZERO_TRIGGER_MODE_IN ? pin_rise[0] : pin_s2_reg[0];
  end

  logic [3:0] pres_ch_reg, pres_ch_next;
  logic irq_reg, irq_next, irq_dma_reg, irq_dma_next;
  logic [7:0] vec_reg, vec_next;
  logic fb_reg, fb_next;
  logic [3:0] fb_ch_reg, fb_ch_next;
  logic accept;
  logic [7:0] clr_code;

  // Clear by code written to the upper status location only
  always_comb begin
    wr_hit_clr = BUS_WR_IN && (BUS_ADDR_IN == ADDR_PEND_CLR);
    clr_code = BUS_WDATA_IN - VEC_DIV8_FIRST;
    accept = irq_reg && IRQ_ACK_IN;
    clr_vec = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (wr_hit_clr && clr_code == 8'(i)) begin
        clr_vec[i] = 1'b1;
      end
      if (accept && !fb_reg && pres_ch_reg == 4'(i)) begin
        clr_vec[i] = 1'b1;
      end
    end
    // Set wins over clear; level mode simply follows the pin
    pend_next = (pend_reg & ~clr_vec) | set_vec;
    if (!EXT_ZERO_TRIGGER_MODE_IN) begin
      pend_next[EXT0_CH] = pin_s2_reg[0];
    end
  end

  // Register writes
  always_comb begin
    en_low_next = en_low_reg;
    en_sel_next = en_sel_reg;
    dma_en_next = dma_en_reg;
    if (BUS_WR_IN) begin
      unique case (BUS_ADDR_IN)
        ADDR_EN_LOW: en_low_next = BUS_WDATA_IN;
        ADDR_EN_DMA_SEL: en_sel_next = BUS_WDATA_IN;
        ADDR_DMA_EN: dma_en_next = BUS_WDATA_IN;
        default: ;
      endcase
    end
  end

  logic [7:0] rdata_next, rdata_reg;
  // Read mux; status shows latches, unmapped reads zero
  always_comb begin
    rdata_next = rdata_reg;
    if (BUS_RD_IN) begin
      unique case (BUS_ADDR_IN)
        ADDR_EN_LOW: rdata_next = en_low_reg;
        ADDR_EN_DMA_SEL: rdata_next = en_sel_reg;
        ADDR_DMA_EN: rdata_next = dma_en_reg;
        ADDR_PEND_LOW: rdata_next = {pend_reg[3:0], 4'h0};
        ADDR_PEND_CLR: rdata_next = pend_reg[11:4];
        default: rdata_next = RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RESET_N_IN) begin
      en_low_reg <= RST_BYTE;
      en_sel_reg <= RST_BYTE;
      dma_en_reg <= RST_BYTE;
      pend_reg <= '0;
      rdata_reg <= RST_BYTE;
    end else begin
      en_low_reg <= en_low_next;
      en_sel_reg <= en_sel_next;
      dma_en_reg <= dma_en_next;
      pend_reg <= pend_next;
      rdata_reg <= rdata_next;
    end
  end

  // Engine state
  icdma_state_t st_reg, st_next;
  icdma_param_t prm_reg, prm_next;
  logic [3:0] ch_reg, ch_next;
  logic [2:0] idx_reg, idx_next;
  logic [SVC_CNT_W-1:0] svc_reg, svc_next;
  logic req_reg, req_next, we_reg, we_next;
  logic busy_reg, busy_next;
  logic [15:0] addr_reg, addr_next;
  logic [7:0] wd_reg, wd_next;
  logic fi_ready, fo_valid, fo_ready, fi_valid;
  logic [7:0] fo_data;
  logic two_byte;
  logic [7:0] cnt_dec;

  icdma_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(MCLK_IN),
    .rst_n_in(RESET_N_IN),
    .in_valid_in(fi_valid),
    .in_ready_out(fi_ready),
    .in_data_in(MEM_RDATA_IN),
    .out_valid_out(fo_valid),
    .out_ready_in(fo_ready),
    .out_data_out(fo_data)
  );

  // Fixed priority: lowest index wins; no look at what is in service
  function automatic logic [4:0] pick(input logic [NUM_CH-1:0] req);
    pick = 5'h10;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (req[i]) begin
        pick = 5'(i);
      end
    end
  endfunction

  logic [4:0] win;
  // Presenter: fallback after count zero goes first, as ordinary vectoring
  always_comb begin
    win = pick(pend_reg & en_vec);
    irq_next = 1'b0;
    pres_ch_next = pres_ch_reg;
    irq_dma_next = 1'b0;
    vec_next = vec_reg;
    fb_next = fb_reg;
    fb_ch_next = fb_ch_reg;
    if (accept && fb_reg) begin
      fb_next = 1'b0;
    end
    if (st_reg == ST_IDLE && !accept) begin
      if (fb_reg) begin
        irq_next = 1'b1;
        pres_ch_next = fb_ch_reg;
      end else if (!win[4]) begin
        irq_next = 1'b1;
        pres_ch_next = win[3:0];
        irq_dma_next = dma_vec[win[3:0]];
      end
      vec_next = 8'({pres_ch_next, 3'b000} + {VEC_DIV8_FIRST, 3'b000});
    end
    if (st_reg == ST_SAVE && MEM_ACK_IN && idx_reg == WB_LAST && prm_reg.count == 8'h00) begin
      fb_next = 1'b1;
      fb_ch_next = ch_reg;
    end
  end

  // Micro DMA engine: load, copy through FIFO, write back, pad
  always_comb begin
    st_next = st_reg;
    prm_next = prm_reg;
    ch_next = ch_reg;
    idx_next = idx_reg;
    svc_next = (svc_reg == '1) ? svc_reg : svc_reg + 1'b1;
    req_next = req_reg;
    we_next = we_reg;
    addr_next = addr_reg;
    wd_next = wd_reg;
    fi_valid = 1'b0;
    fo_ready = 1'b0;
    two_byte = prm_reg.mode[WIDTH_BIT];
    cnt_dec = prm_reg.count - 8'h01;
    unique case (st_reg)
      ST_IDLE: begin
        if (accept && irq_dma_reg && !fb_reg) begin
          st_next = ST_LOAD;
          ch_next = pres_ch_reg;
          idx_next = 3'h0;
          svc_next = '0;
          req_next = 1'b1;
          we_next = 1'b0;
          addr_next = PARAM_BASE + 16'(vec_reg);
        end
      end
      ST_LOAD: begin
        if (MEM_ACK_IN) begin
          unique case (idx_reg)
            OFS_COUNT: prm_next.count = MEM_RDATA_IN;
            3'h1: prm_next.dst[7:0] = MEM_RDATA_IN;
            3'h2: prm_next.dst[15:8] = MEM_RDATA_IN;
            3'h3: prm_next.src[7:0] = MEM_RDATA_IN;
            3'h4: prm_next.src[15:8] = MEM_RDATA_IN;
            default: prm_next.mode = MEM_RDATA_IN;
          endcase
          if (idx_reg == 3'(PARAM_BYTES - 1)) begin
            st_next = ST_READ;
            idx_next = 3'h0;
            req_next = 1'b0;
          end else begin
            idx_next = idx_reg + 3'h1;
            addr_next = addr_reg + 16'h0001;
          end
        end
      end
      ST_READ: begin
        // Source bytes fill the FIFO; a full FIFO holds the request back
        fi_valid = MEM_ACK_IN;
        if (MEM_ACK_IN) begin
          req_next = 1'b0;
          if (idx_reg[0] == two_byte) begin
            st_next = ST_WRITE;
            idx_next = 3'h0;
          end else begin
            idx_next = 3'h1;
          end
        end else if (!req_reg && fi_ready) begin
          req_next = 1'b1;
          we_next = 1'b0;
          addr_next = prm_reg.src + 16'(idx_reg[0]);
        end
      end
      ST_WRITE: begin
        if (MEM_ACK_IN) begin
          req_next = 1'b0;
          if (idx_reg[0] == two_byte) begin
            st_next = ST_SAVE;
            idx_next = 3'h0;
            // Step by width per update code
            unique case (icdma_upd_t'(prm_reg.mode[1:0]))
              UPD_FIXED: ;
              UPD_DST_INC: prm_next.dst = prm_reg.dst + (two_byte ? 16'h0002 : 16'h0001);
              UPD_SRC_INC: prm_next.src = prm_reg.src + (two_byte ? 16'h0002 : 16'h0001);
              UPD_SRC_DEC: prm_next.src = prm_reg.src - (two_byte ? 16'h0002 : 16'h0001);
            endcase
            prm_next.count = cnt_dec;
          end else begin
            idx_next = 3'h1;
          end
        end else if (!req_reg && fo_valid) begin
          fo_ready = 1'b1;
          req_next = 1'b1;
          we_next = 1'b1;
          wd_next = fo_data;
          addr_next = prm_reg.dst + 16'(idx_reg[0]);
        end
      end
      ST_SAVE: begin
        // Only parameter bytes are touched; no CPU register is written
        if (MEM_ACK_IN) begin
          req_next = 1'b0;
          if (idx_reg == WB_LAST) begin
            st_next = (prm_reg.count == 8'h00) ? ST_IDLE : ST_PAD;
          end else begin
            idx_next = idx_reg + 3'h1;
          end
        end else if (!req_reg) begin
          req_next = 1'b1;
          we_next = 1'b1;
          addr_next = PARAM_BASE + 16'(vec_reg) + 16'(idx_reg);
          unique case (idx_reg)
            OFS_COUNT: wd_next = prm_reg.count;
            3'h1: wd_next = prm_reg.dst[7:0];
            3'h2: wd_next = prm_reg.dst[15:8];
            3'h3: wd_next = prm_reg.src[7:0];
            default: wd_next = prm_reg.src[15:8];
          endcase
        end
      end
      ST_PAD: begin
        // Fixed service length hides width; slow memory can only stretch it
        if (svc_reg >= SVC_CNT_W'(SVC_CYCLES - 1)) begin
          st_next = ST_IDLE;
        end
      end
      default: st_next = ST_IDLE;
    endcase
    // Busy flag registered so the output comes from a flip-flop
    busy_next = (st_next != ST_IDLE);
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RESET_N_IN) begin
      st_reg <= ST_IDLE;
      prm_reg <= '0;
      ch_reg <= '0;
      idx_reg <= '0;
      svc_reg <= '0;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      busy_reg <= 1'b0;
      addr_reg <= '0;
      wd_reg <= RST_BYTE;
      irq_reg <= 1'b0;
      irq_dma_reg <= 1'b0;
      pres_ch_reg <= '0;
      vec_reg <= RST_BYTE;
      fb_reg <= 1'b0;
      fb_ch_reg <= '0;
    end else begin
      st_reg <= st_next;
      prm_reg <= prm_next;
      ch_reg <= ch_next;
      idx_reg <= idx_next;
      svc_reg <= svc_next;
      req_reg <= req_next;
      we_reg <= we_next;
      busy_reg <= busy_next;
      addr_reg <= addr_next;
      wd_reg <= wd_next;
      irq_reg <= irq_next;
      irq_dma_reg <= irq_dma_next;
      pres_ch_reg <= pres_ch_next;
      vec_reg <= vec_next;
      fb_reg <= fb_next;
      fb_ch_reg <= fb_ch_next;
    end
  end

  // Outputs straight from flip-flops
  assign BUS_RDATA_OUT = rdata_reg;
  assign IRQ_OUT = irq_reg;
  assign IRQ_VECTOR_OUT = vec_reg;
  assign IRQ_DMA_OUT = irq_dma_reg;
  assign DMA_BUSY_OUT = busy_reg;
  assign MEM_REQ_OUT = req_reg;
  assign MEM_WE_OUT = we_reg;
  assign MEM_ADDR_OUT = addr_reg;
  assign MEM_WDATA_OUT = wd_reg;

  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  sequence s_dma_accept;
    accept && irq_dma_reg && !fb_reg && st_reg == ST_IDLE;
  endsequence

  a_param_base_addr: assert property (s_dma_accept |=>
    MEM_ADDR_OUT == PARAM_BASE + 16'(vec_reg) && MEM_REQ_OUT && !MEM_WE_OUT)
    else $error("parameter load address wrong");
  a_serial_no_dma: assert property (irq_reg && pres_ch_reg == 4'(SERIAL_CH) |-> !irq_dma_reg)
    else $error("serial channel offered as micro DMA");
  a_clear_by_code: assert property (wr_hit_clr && clr_code < 8'(NUM_CH)
    && !set_vec[clr_code[3:0]] |=> !pend_reg[$past(clr_code[3:0])])
    else $error("clear by code did not clear latch");
  a_low_no_clear: assert property (BUS_WR_IN && BUS_ADDR_IN == ADDR_PEND_LOW
    && !accept |=> (~pend_reg[11:1] & $past(pend_reg[11:1])) == 11'h000)
    else $error("write to lower status location changed latches");
  a_status_read: assert property (BUS_RD_IN && BUS_ADDR_IN == ADDR_PEND_CLR
    |=> BUS_RDATA_OUT == $past(pend_reg[11:4]))
    else $error("status read does not show latches");
  a_set_wins: assert property (set_vec[1] && clr_vec[1] |=> pend_reg[1])
    else $error("set lost against clear");
  a_priority_low: assert property (irq_reg && !fb_reg |->
    ($past(pend_reg & en_vec) & ((NUM_CH)'(1) << pres_ch_reg)) != '0
    && ($past(pend_reg & en_vec) & (((NUM_CH)'(1) << pres_ch_reg) - (NUM_CH)'(1))) == '0)
    else $error("presented channel not the highest pending enabled one");
  a_shared_select: assert property (!en_sel_reg[SEL_BIT] && SYNC_FLAG_IRQ_IN
    |=> pend_reg[SHARED_CH])
    else $error("sync flag not routed to shared channel");
  a_fallback_zero: assert property (st_reg == ST_SAVE && MEM_ACK_IN && idx_reg == WB_LAST
    && prm_reg.count == 8'h00 |=> st_reg == ST_IDLE ##1 IRQ_OUT && !IRQ_DMA_OUT)
    else $error("count zero did not fall back to vectoring");
  a_pad_length: assert property (st_reg == ST_PAD && $past(st_reg) != ST_PAD
    |-> svc_reg <= SVC_CNT_W'(SVC_CYCLES - 1))
    else $error("service overran before padding");
endmodule

// ---- tb/icdma_mem_model.sv ----
// Byte-wide memory on the engine's port, standing in for the CPU address space.
// Assumes the controller's clock; acknowledges after delay_in idle cycles.
`timescale 1ns/10ps
module icdma_mem_model (
  input wire logic clk_in,
  input wire logic req_in,
  input wire logic we_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [3:0] delay_in,
  output logic [7:0] rdata_out,
  output logic ack_out
);
  logic [7:0] mem [0:65535];
  logic [3:0] wait_reg;
  initial begin
    ack_out = 1'b0;
    rdata_out = 8'h5a;
    wait_reg = 4'h0;
  end
  // One-cycle ack; read data is flipped outside it so a late sample shows up
  always @(posedge clk_in) begin
    if (ack_out || !req_in) begin
      ack_out <= 1'b0;
      wait_reg <= 4'h0;
      rdata_out <= ~rdata_out;
    end else if (wait_reg >= delay_in) begin
      ack_out <= 1'b1;
      wait_reg <= 4'h0;
      if (we_in) mem[addr_in] <= wdata_in;
      rdata_out <= mem[addr_in];
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule

// ---- tb/interrupt_controller_micro_dma_bench.sv ----
// Self-checking bench for the interrupt controller and micro DMA engine.
// Assumes the memory model answers the engine; CPU accesses are made by tasks.
`timescale 1ns/10ps
module interrupt_controller_micro_dma_bench;
  import icdma_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ack = 1'b0, sync = 1'b0, zmode = 1'b0;
  logic [2:0] pin = 3'h0;
  logic [11:0] src = 12'h000;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata, vec, mwd, mrd;
  logic irq, dma, busy, mreq, mwe, mack;
  logic [15:0] maddr;
  logic [3:0] dly = 4'h0;
  int bad_count = 0, cmp_count = 0, first_n = 0;
  always #5 clk = ~clk;
  icdma_top u_dut (.MCLK_IN(clk), .RESET_N_IN(rst_n), .EXT_IRQ_PIN_IN(pin),
    .EXT_ZERO_TRIGGER_MODE_IN(zmode), .SYNC_FLAG_IRQ_IN(sync), .INT_SRC_IN(src),
    .BUS_ADDR_IN(addr), .BUS_WDATA_IN(wdata), .BUS_WR_IN(wr), .BUS_RD_IN(rd),
    .BUS_RDATA_OUT(rdata), .IRQ_OUT(irq), .IRQ_VECTOR_OUT(vec), .IRQ_DMA_OUT(dma),
    .IRQ_ACK_IN(ack), .DMA_BUSY_OUT(busy), .MEM_REQ_OUT(mreq), .MEM_WE_OUT(mwe),
    .MEM_ADDR_OUT(maddr), .MEM_WDATA_OUT(mwd), .MEM_RDATA_IN(mrd), .MEM_ACK_IN(mack));
  icdma_mem_model u_mem (.clk_in(clk), .req_in(mreq), .we_in(mwe), .addr_in(maddr),
    .wdata_in(mwd), .delay_in(dly), .rdata_out(mrd), .ack_out(mack));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Register write and read; read data is registered one cycle later
  // An idle edge follows so a second call never re-raises a strobe at once
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    chk(rdata, e);
    cyc(1);
  endtask
  task automatic pulse(input logic [11:0] m);
    src = m;
    cyc(1);
    src = 12'h000;
  endtask
  // Wait for a presented channel, compare it, then accept it
  task automatic take(input logic [7:0] v, input logic d);
    for (int i = 0; i < 2000 && irq !== 1'b1; i++) cyc(1);
    chk(irq, 1'b1);
    chk(vec, v);
    chk(dma, d);
    ack = 1'b1;
    cyc(1);
    ack = 1'b0;
  endtask
  task automatic t_reset;
    rd_chk(ADDR_EN_LOW, 8'h00);
    rd_chk(ADDR_EN_DMA_SEL, 8'h00);
    rd_chk(ADDR_DMA_EN, 8'h00);
    rd_chk(ADDR_PEND_LOW, 8'h00);
    rd_chk(ADDR_PEND_CLR, 8'h00);
    wr_reg(ADDR_EN_DMA_SEL, 8'h07);
    rd_chk(ADDR_EN_DMA_SEL, 8'h07);
    wr_reg(ADDR_EN_DMA_SEL, 8'h00);
    $display("test reset done");
  endtask
  // Enables stay off while clearing
  task automatic t_clear;
    pulse(12'h022);
    cyc(2);
    wr_reg(ADDR_PEND_LOW, 8'h00);
    rd_chk(ADDR_PEND_LOW, 8'h20);
    rd_chk(ADDR_PEND_CLR, 8'h02);
    wr_reg(ADDR_PEND_CLR, 8'h06);
    wr_reg(ADDR_PEND_CLR, 8'h0a);
    rd_chk(ADDR_PEND_LOW, 8'h00);
    rd_chk(ADDR_PEND_CLR, 8'h00);
    // Event and clear by code in one cycle: the event must win
    addr = ADDR_PEND_CLR;
    wdata = 8'h06;
    wr = 1'b1;
    src = 12'h002;
    cyc(1);
    wr = 1'b0;
    src = 12'h000;
    cyc(1);
    rd_chk(ADDR_PEND_LOW, 8'h20);
    wr_reg(ADDR_PEND_CLR, 8'h06);
    $display("test clear done");
  endtask
  task automatic t_prio;
    wr_reg(ADDR_DMA_EN, 8'h08);
    wr_reg(ADDR_EN_LOW, 8'h1c);
    pulse(12'h01c);
    take(8'h38, 1'b0);
    take(8'h40, 1'b0);
    take(8'h48, 1'b0);
    cyc(2);
    chk(irq, 1'b0);
    rd_chk(ADDR_PEND_CLR, 8'h00);
    $display("test priority done");
  endtask
  // Parameter block of channel four sits at base plus 0x48
  task automatic setp(input logic [7:0] c, input logic [15:0] d, input logic [15:0] s,
                      input logic [7:0] m);
    u_mem.mem[16'hff48] = c;
    {u_mem.mem[16'hff4a], u_mem.mem[16'hff49]} = d;
    {u_mem.mem[16'hff4c], u_mem.mem[16'hff4b]} = s;
    u_mem.mem[16'hff4d] = m;
  endtask
  task automatic service(input logic d, output int n);
    pulse(12'h010);
    take(8'h48, d);
    n = 1;
    while (n < 2000 && busy === 1'b1) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic t_dma;
    int n, w;
    logic [15:0] ed, es;
    wr_reg(ADDR_DMA_EN, 8'h10);
    wr_reg(ADDR_EN_LOW, 8'h10);
    for (int m = 0; m < 8; m++) begin
      dly = 4'(m);
      w = m[2] ? 2 : 1;
      ed = 16'hf800 + ((m[1:0] == 2'b01) ? 16'(w) : 16'h0000);
      es = 16'h0010 + ((m[1:0] == 2'b10) ? 16'(w) : 16'h0000)
        - ((m[1:0] == 2'b11) ? 16'(w) : 16'h0000);
      setp(8'h02, 16'hf800, 16'h0010, 8'(m));
      u_mem.mem[16'h0010] = 8'ha0 + 8'(m);
      u_mem.mem[16'h0011] = 8'hb0 + 8'(m);
      u_mem.mem[16'hf801] = 8'h00;
      service(1'b1, n);
      if (m == 0) first_n = n;
      chk(16'(n), 16'(first_n));
      chk(16'(n > SVC_CYCLES - 4 && n < SVC_CYCLES + 4), 16'h0001);
      chk(u_mem.mem[16'hf800], 8'ha0 + 8'(m));
      chk(u_mem.mem[16'hf801], m[2] ? 8'hb0 + 8'(m) : 8'h00);
      chk(u_mem.mem[16'hff48], 8'h01);
      chk({u_mem.mem[16'hff4a], u_mem.mem[16'hff49]}, ed);
      chk({u_mem.mem[16'hff4c], u_mem.mem[16'hff4b]}, es);
    end
    dly = 4'h0;
    setp(8'h01, 16'hf800, 16'h0010, 8'h00);
    service(1'b1, n);
    take(8'h48, 1'b0);
    chk(u_mem.mem[16'hff48], 8'h00);
    setp(8'h00, 16'hf800, 16'h0010, 8'h00);
    service(1'b1, n);
    cyc(3);
    chk(irq, 1'b0);
    chk(u_mem.mem[16'hff48], 8'hff);
    wr_reg(ADDR_EN_LOW, 8'h00);
    $display("test dma done");
  endtask
  task automatic t_pins;
    pin[0] = 1'b1;
    cyc(5);
    rd_chk(ADDR_PEND_LOW, 8'h10);
    pin[0] = 1'b0;
    cyc(5);
    rd_chk(ADDR_PEND_LOW, 8'h00);
    zmode = 1'b1;
    pin = 3'h7;
    cyc(5);
    pin = 3'h0;
    cyc(5);
    rd_chk(ADDR_PEND_LOW, 8'h10);
    rd_chk(ADDR_PEND_CLR, 8'h20);
    wr_reg(ADDR_PEND_CLR, 8'h05);
    wr_reg(ADDR_PEND_CLR, 8'h0e);
    sync = 1'b1;
    cyc(1);
    sync = 1'b0;
    cyc(2);
    rd_chk(ADDR_PEND_CLR, 8'h40);
    wr_reg(ADDR_PEND_CLR, 8'h0f);
    wr_reg(ADDR_EN_DMA_SEL, 8'h08);
    pin[2] = 1'b1;
    cyc(5);
    rd_chk(ADDR_PEND_CLR, 8'h40);
    $display("test pins done");
  endtask
  // Reset in mid-run drops latches, flags and the presented request
  task automatic t_rerun;
    pulse(12'h022);
    wr_reg(ADDR_EN_LOW, 8'h02);
    rst_n = 1'b0;
    cyc(3);
    rst_n = 1'b1;
    rd_chk(ADDR_PEND_LOW, 8'h00);
    rd_chk(ADDR_PEND_CLR, 8'h00);
    rd_chk(ADDR_EN_LOW, 8'h00);
    chk(irq, 1'b0);
    $display("test mid-run reset done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Tests need about 8500 cycles; the watchdog allows about seven times that
  initial begin
    #600000;
    bad_count++;
    tally_and_finish;
  end
  initial begin
    cyc(12);
    rst_n = 1'b1;
    t_reset;
    t_clear;
    t_prio;
    t_dma;
    t_pins;
    t_rerun;
    tally_and_finish;
  end
endmodule
